/* hw/isp_cycle_timer.sv */
// down counter giving a one-cycle done pulse a fixed number of cycles
// after a start pulse; a new start restarts it, abort stops it.
// assumes start and abort are on ref_clk.
`timescale 1ns/1ps
module isp_cycle_timer #(
  parameter int COUNT = 80,
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic done
);

  logic [WIDTH-1:0] count;
  logic busy;
  logic [WIDTH-1:0] next_count;
  logic next_busy;
  logic next_done;

  if (COUNT < 1 || COUNT >= (1 << WIDTH)) begin : g_bad_count
    $error("isp_cycle_timer: COUNT does not fit WIDTH");
  end

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (abort) begin
      next_busy = 1'b0;
    end else if (start) begin
      next_count = WIDTH'(COUNT - 1);
      next_busy = 1'b1;
    end else if (busy) begin
      if (count == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : isp_cycle_timer

/* hw/isp_defines.svh */
// constants for the i2c stop trigger and status block: offsets, bit positions,
// reset values and timing counts.
// assumes the including file needs nothing else defined beforehand.
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses on the cpu bus
// ----------------------------------------------------------------------------
`define ISP_STATUS_ADDR 16'hffaa
`define ISP_CONTROL_ADDR 16'hffa6

// ----------------------------------------------------------------------------
// bus_control_zero bit positions
// ----------------------------------------------------------------------------
`define ISP_CTRL_STOP 0
`define ISP_CTRL_START 1
`define ISP_CTRL_ACKE 2
`define ISP_CTRL_WTIM 3
`define ISP_CTRL_LEAVE 6
`define ISP_CTRL_ENABLE 7

// ----------------------------------------------------------------------------
// bus_status bit positions
// ----------------------------------------------------------------------------
`define ISP_STAT_MASTER 7
`define ISP_STAT_ARB_LOST 6
`define ISP_STAT_TRANSMIT 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ISP_STATUS_RESET 8'h00
`define ISP_CONTROL_RESET 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ISP_REF_CLK_NS 50
`define ISP_STOP_SETUP_NS 4000
`define ISP_STOP_SETUP_CYC ((`ISP_STOP_SETUP_NS + `ISP_REF_CLK_NS - 1) / `ISP_REF_CLK_NS)

`endif

/* hw/isp_pkg.sv */
// types shared by the i2c stop trigger and status block.
// assumes nothing of its surroundings.
package isp_pkg;

  // --------------------------------------------------------------------------
  // register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic interface_enable;
    logic leave_communication;
    logic [1:0] spare;
    logic wait_timing_select;
    logic acknowledge_enable;
    logic start_trigger;
    logic stop_trigger;
  } isp_ctrl_t;

  typedef struct packed {
    logic master_active;
    logic arbitration_lost;
    logic [5:0] other;
  } isp_status_t;

  // --------------------------------------------------------------------------
  // stop sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NINTH,
    ST_SDA_LOW,
    ST_SCL_HIGH,
    ST_HOLD,
    ST_SDA_UP
  } isp_stop_state_t;

endpackage : isp_pkg

/* hw/isp_stop_status.sv */
// i2c stop trigger, its stop sequencer, and the master-active and
// arbitration-lost status flags, with the cpu register port.
// assumes the shift and start logic on ref_clk supply the event inputs, and
// that the serial pins are open drain with pull-ups outside.
//
// Overview of operation
// - stop: sda low, scl high, wait, sda up
// - wtim zero: stop in ninth clock high
// - stop trigger cleared by listed events only
// - stop trigger bit reads back zero
// - transmit status: release wait at ninth clock
// - status resets to all zeros
// - status read inserts one cpu wait
// - master active: set start, cleared events
// - arbitration lost: sticky, cleared by read
`timescale 1ns/1ps
`include "isp_defines.svh"
module isp_stop_status
  import isp_pkg::*;
#(
  parameter int STOP_SETUP_CYC = `ISP_STOP_SETUP_CYC,
  parameter int TIMER_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // cpu register port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_wait,
  // serial pins
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // events from the shift and start logic
  input wire logic start_generated,
  input wire logic arb_lost_event,
  input wire logic eight_clock_wait,
  input wire logic ninth_clock,
  input wire logic [5:0] low_status,
  // controls to the rest of the interface
  output logic start_trigger,
  output logic stop_trigger,
  output logic wait_timing_select,
  output logic acknowledge_enable,
  output logic interface_enable,
  output logic leave_communication,
  output logic wait_release,
  output logic transmit_clear,
  output logic stop_detected,
  output logic master_active
);

  // --------------------------------------------------------------------------
  // pin synchronisers and stop detection
  // --------------------------------------------------------------------------
  logic [1:0] line_sync;
  logic scl_s, sda_s, sda_q, ninth_q, stop_seen;

  isp_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({serial_clock_line_in, serial_data_line_in}),
    .sync_out(line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];
  // data rising while clock high
  assign stop_seen = scl_s && sda_s && !sda_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 1'b1;
      ninth_q <= 1'b0;
    end else begin
      sda_q <= sda_s;
      ninth_q <= ninth_clock;
    end
  end

  // --------------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  isp_ctrl_t ctrl, next_ctrl;
  isp_status_t status, next_status;
  logic ctrl_wr, status_rd, ctrl_rd, en_fall, en_q, arb_ev, start_ev;

  assign ctrl_wr = cpu_wr && hit(cpu_addr, `ISP_CONTROL_ADDR);
  // a write to the status address decodes to nothing
  assign status_rd = cpu_rd && hit(cpu_addr, `ISP_STATUS_ADDR);
  assign ctrl_rd = cpu_rd && hit(cpu_addr, `ISP_CONTROL_ADDR);
  assign en_fall = en_q && !ctrl.interface_enable;
  // bus events mean nothing while the interface is stopped
  assign arb_ev = arb_lost_event && ctrl.interface_enable;
  assign start_ev = start_generated && ctrl.interface_enable;

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_ctrl.leave_communication = 1'b0;
    next_ctrl.spare = 2'h0;
    // hardware clears first; a write in the same cycle then wins
    if (arb_ev || stop_seen) begin
      next_ctrl.stop_trigger = 1'b0;
    end
    if (arb_ev || start_ev) begin
      next_ctrl.start_trigger = 1'b0;
    end
    if (ctrl_wr) begin
      next_ctrl.interface_enable = cpu_wdata[`ISP_CTRL_ENABLE];
      next_ctrl.wait_timing_select = cpu_wdata[`ISP_CTRL_WTIM];
      next_ctrl.acknowledge_enable = cpu_wdata[`ISP_CTRL_ACKE];
      next_ctrl.leave_communication = cpu_wdata[`ISP_CTRL_LEAVE];
      // trigger bits in a write only ever set a trigger; writing zero to one never clears it
      if (cpu_wdata[`ISP_CTRL_STOP]) begin
        next_ctrl.stop_trigger = 1'b1;
      end
      if (cpu_wdata[`ISP_CTRL_START]) begin
        next_ctrl.start_trigger = 1'b1;
      end
    end
    // leaving or stopping the interface overrides any pending trigger
    if (next_ctrl.leave_communication || !next_ctrl.interface_enable) begin
      next_ctrl.stop_trigger = 1'b0;
      next_ctrl.start_trigger = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= isp_ctrl_t'(`ISP_CONTROL_RESET);
      en_q <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      en_q <= ctrl.interface_enable;
    end
  end

  // --------------------------------------------------------------------------
  // status register
  // --------------------------------------------------------------------------
  always_comb begin
    next_status = status;
    next_status.other = low_status;
    // a loss clears master; a start in the same cycle as a stop keeps it
    if (arb_ev || en_fall) begin
      next_status.master_active = 1'b0;
    end else if (start_ev) begin
      next_status.master_active = 1'b1;
    end else if (stop_seen || ctrl.leave_communication) begin
      next_status.master_active = 1'b0;
    end
    // a loss arriving with the read is kept for the next read
    if (arb_ev) begin
      next_status.arbitration_lost = 1'b1;
    end else if (status_rd || en_fall) begin
      next_status.arbitration_lost = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= isp_status_t'(`ISP_STATUS_RESET);
    end else begin
      status <= next_status;
    end
  end

  // --------------------------------------------------------------------------
  // stop sequencer
  // --------------------------------------------------------------------------
  isp_stop_state_t state, next_state;
  logic timer_start, timer_abort, timer_done, go_release, abort;

  assign abort = !ctrl.stop_trigger;

  always_comb begin
    next_state = state;
    go_release = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ctrl.stop_trigger) begin
          go_release = 1'b1;
          // wait after eight clocks with wtim clear: stop rides the ninth clock
          if (eight_clock_wait && !ctrl.wait_timing_select) begin
            next_state = ST_NINTH;
          end else begin
            next_state = ST_SDA_LOW;
          end
        end
      end
      ST_NINTH: begin
        if (scl_s) begin
          next_state = ST_HOLD;
        end
      end
      ST_SDA_LOW: begin
        if (timer_done) begin
          next_state = ST_SCL_HIGH;
        end
      end
      ST_SCL_HIGH: begin
        // a slave may still stretch the clock
        if (scl_s) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          next_state = ST_SDA_UP;
        end
      end
      ST_SDA_UP: begin
        if (stop_seen) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (abort && state != ST_IDLE) begin
      next_state = ST_IDLE;
    end
  end

  assign timer_start = (next_state != state) &&
                       (next_state == ST_SDA_LOW || next_state == ST_HOLD);
  assign timer_abort = (next_state == ST_IDLE);

  isp_cycle_timer #(
    .COUNT(STOP_SETUP_CYC),
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(timer_start),
    .abort(timer_abort),
    .done(timer_done)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  logic [7:0] next_rdata;
  logic tx_release, next_sda_oe, next_scl_oe;

  // transmitter hands the line back as the ninth clock begins
  assign tx_release = low_status[`ISP_STAT_TRANSMIT] && ninth_clock && !ninth_q;

  always_comb begin
    next_rdata = 8'h00;
    if (status_rd) begin
      next_rdata = status;
    end else if (ctrl_rd) begin
      next_rdata = ctrl;
      next_rdata[`ISP_CTRL_STOP] = 1'b0;
      next_rdata[`ISP_CTRL_START] = 1'b0;
      next_rdata[`ISP_CTRL_LEAVE] = 1'b0;
    end
    next_sda_oe = (next_state == ST_NINTH) || (next_state == ST_SDA_LOW) ||
                  (next_state == ST_SCL_HIGH) || (next_state == ST_HOLD);
    if (tx_release) begin
      next_sda_oe = 1'b0;
    end
    next_scl_oe = (next_state == ST_SDA_LOW);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
      cpu_wait <= 1'b0;
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= 1'b0;
      wait_release <= 1'b0;
      transmit_clear <= 1'b0;
      stop_detected <= 1'b0;
    end else begin
      cpu_rdata <= next_rdata;
      // the status read is stretched by one cycle
      cpu_wait <= status_rd;
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe <= next_scl_oe;
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= next_sda_oe;
      wait_release <= go_release || tx_release;
      transmit_clear <= tx_release;
      stop_detected <= stop_seen;
    end
  end

  // copies of control and status state, each straight from its register
  assign start_trigger = ctrl.start_trigger;
  assign stop_trigger = ctrl.stop_trigger;
  assign wait_timing_select = ctrl.wait_timing_select;
  assign acknowledge_enable = ctrl.acknowledge_enable;
  assign interface_enable = ctrl.interface_enable;
  assign leave_communication = ctrl.leave_communication;
  assign master_active = status.master_active;

endmodule : isp_stop_status

/* hw/isp_sync2.sv */
// two flip-flop synchroniser for the serial pins.
// assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module isp_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("isp_sync2: WIDTH must be at least 1");
  end

  // idle bus lines are high, so reset to high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : isp_sync2

/* sim/isp_bus_partner.sv */
// far side of the serial bus: pull-ups, a bus clock in frames, a stretching slave.
// assumes open-drain enables that are high while the block pulls a line low.
`timescale 1ns/1ps
module isp_bus_partner (
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic frame,
  input wire logic stretch,
  output logic scl,
  output logic sda
);
  logic phase = 1'b1;
  // the clock runs at 400 ns only inside a frame and stands high outside it
  always begin
    #200;
    phase = frame ? !phase : 1'b1;
  end
  // released lines go to the pull-up level, driven ones show the driven level;
  // a slow slave holds the clock low
  assign scl = !stretch && phase && (scl_oe ? scl_out : 1'b1);
  assign sda = sda_oe ? sda_out : 1'b1;
endmodule : isp_bus_partner

/* sim/isp_stop_status_asserts.sv */
// timing checks on the stop trigger and status block, bound to its ports.
// assumes one ref_clk domain with rst_n asynchronous, active low.
`timescale 1ns/1ps
module isp_stop_status_asserts #(
  parameter int STOP_SETUP_CYC = 80
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_wait,
  input wire logic serial_clock_line_in,
  input wire logic serial_clock_line_oe,
  input wire logic serial_data_line_oe,
  input wire logic start_generated,
  input wire logic arb_lost_event,
  input wire logic ninth_clock,
  input wire logic [5:0] low_status,
  input wire logic stop_trigger,
  input wire logic interface_enable,
  input wire logic wait_release,
  input wire logic transmit_clear,
  input wire logic master_active
);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // -------------------------------------------------------------------------
  // data-low time with the clock let go, saturating so it never wraps
  // -------------------------------------------------------------------------
  always_comb begin
    next_low_cnt = low_cnt;
    if (!serial_data_line_oe || serial_clock_line_oe) next_low_cnt = 8'h00;
    else if (low_cnt != 8'hff) next_low_cnt = low_cnt + 8'h01;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 8'h00;
    else low_cnt <= next_low_cnt;
  end
  sequence s_stat_rd;
    cpu_rd && cpu_addr == 16'hffaa;
  endsequence
  sequence s_stop_go;
    wait_release && serial_data_line_oe;
  endsequence
  sequence s_sda_up;
    $fell(serial_data_line_oe) && stop_trigger;
  endsequence
  a_status_read_wait: assert property (s_stat_rd |=> cpu_wait)
    else $error("no wait cycle after status read");
  a_stop_reads_zero: assert property (cpu_rd && cpu_addr == 16'hffa6 |=> !cpu_rdata[0])
    else $error("stop trigger read back as one");
  a_stop_starts_low: assert property ($rose(stop_trigger) |=> s_stop_go)
    else $error("stop did not pull data low");
  a_stop_hold_time: assert property (s_sda_up |-> $past(low_cnt) >= STOP_SETUP_CYC)
    else $error("stop setup time too short");
  a_data_rise_clk: assert property (s_sda_up |-> serial_clock_line_in)
    else $error("data rose while clock low");
  a_arb_clears_all: assert property (arb_lost_event && interface_enable && !cpu_wr
      |=> !stop_trigger && !master_active)
    else $error("arbitration loss left trigger or master set");
  a_start_sets_mst: assert property (start_generated && interface_enable && !arb_lost_event
      && !cpu_wr |=> master_active)
    else $error("master active not set by start");
  a_disable_clears: assert property (!interface_enable |-> !stop_trigger)
    else $error("stop trigger set while disabled");
  a_enable_fall_mst: assert property ($fell(interface_enable) |-> ##[0:1] !master_active)
    else $error("master active kept after disable");
  a_transmit_rel: assert property ($rose(ninth_clock) && low_status[3] && interface_enable
      |=> ##[0:1] (wait_release && transmit_clear))
    else $error("no wait release at ninth clock");
endmodule : isp_stop_status_asserts

bind isp_stop_status isp_stop_status_asserts #(.STOP_SETUP_CYC(STOP_SETUP_CYC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
  .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .serial_clock_line_in(serial_clock_line_in),
  .serial_clock_line_oe(serial_clock_line_oe), .serial_data_line_oe(serial_data_line_oe),
  .start_generated(start_generated), .arb_lost_event(arb_lost_event),
  .ninth_clock(ninth_clock), .low_status(low_status), .stop_trigger(stop_trigger),
  .interface_enable(interface_enable), .wait_release(wait_release),
  .transmit_clear(transmit_clear), .master_active(master_active));

/* sim/tb.sv */
// self-checking bench for the stop trigger and status block.
// assumes the partner model for the serial lines and a 20 MHz ref_clk.
`timescale 1ns/1ps
module tb;
  import isp_pkg::*;
  logic ref_clk, rst_n, cpu_wr, cpu_rd, start_generated, arb_lost_event;
  logic eight_clock_wait, ninth_clock, frame, stretch, scl, sda, scl_oe, sda_oe;
  logic cpu_wait, stop_trigger, master_active, wait_release, transmit_clear, stop_detected;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, rv;
  logic [5:0] low_status;
  logic rw, scl_out, sda_out, start_trigger, acknowledge_enable, interface_enable;
  logic wait_timing_select, leave_communication;
  int fails, checks_done, cyc;

  isp_stop_status #(.STOP_SETUP_CYC(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .serial_clock_line_in(scl),
    .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe),
    .serial_data_line_in(sda), .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
    .start_generated(start_generated),
    .arb_lost_event(arb_lost_event), .eight_clock_wait(eight_clock_wait),
    .ninth_clock(ninth_clock), .low_status(low_status), .start_trigger(start_trigger),
    .stop_trigger(stop_trigger), .wait_timing_select(wait_timing_select),
    .acknowledge_enable(acknowledge_enable), .interface_enable(interface_enable),
    .leave_communication(leave_communication), .wait_release(wait_release),
    .transmit_clear(transmit_clear), .stop_detected(stop_detected),
    .master_active(master_active));
  isp_bus_partner u_bus (.scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe),
    .sda_out(sda_out), .frame(frame), .stretch(stretch), .scl(scl), .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // a hung wait ends the run as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1;
    rv = cpu_rdata;
    rw = cpu_wait;
  endtask : rd
  task automatic pulse(input bit arb);
    @(posedge ref_clk);
    if (arb) arb_lost_event <= 1'b1;
    else start_generated <= 1'b1;
    @(posedge ref_clk);
    arb_lost_event <= 1'b0;
    start_generated <= 1'b0;
  endtask : pulse
  // stop_detected stands one cycle, so it is sampled just after every edge
  task automatic wait_stop();
    int n;
    n = 0;
    while (stop_detected !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("stop_detected", 8'h01, {7'h00, stop_detected});
    chk("stop_trigger", 8'h00, {7'h00, stop_trigger});
  endtask : wait_stop

  task automatic t_reset_regs();
    rd(16'hffaa);
    chk("status", 8'h00, rv);
    chk("cpu_wait", 8'h01, {7'h00, rw});
    wr(16'hffaa, 8'hff);
    rd(16'hffaa);
    chk("status", 8'h00, rv);
    rd(16'hffa6);
    chk("control", 8'h00, rv);
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_master_arb();
    wr(16'hffa6, 8'h86);
    #1;
    chk("start_trigger", 8'h01, {7'h00, start_trigger});
    chk("acknowledge_enable", 8'h01, {7'h00, acknowledge_enable});
    frame <= 1'b1;
    rd(16'hffaa);
    chk("status", 8'h00, rv);
    pulse(1'b0);
    rd(16'hffaa);
    chk("status", 8'h80, rv);
    pulse(1'b1);
    rd(16'hffaa);
    chk("status", 8'h40, rv);
    rd(16'hffaa);
    chk("status", 8'h00, rv);
    frame <= 1'b0;
    $display("test master_arb done");
  endtask : t_master_arb
  task automatic t_stop_slow();
    pulse(1'b0);
    stretch <= 1'b1;
    wr(16'hffa6, 8'h89);
    rd(16'hffa6);
    chk("control", 8'h88, rv);
    chk("enables", 8'h07, {5'h00, interface_enable, wait_timing_select, master_active});
    repeat (30) @(posedge ref_clk);
    stretch <= 1'b0;
    wait_stop();
    rd(16'hffaa);
    chk("status", 8'h00, rv);
    $display("test stop_slow done");
  endtask : t_stop_slow
  task automatic t_stop_ninth();
    pulse(1'b0);
    eight_clock_wait <= 1'b1;
    wr(16'hffa6, 8'h81);
    wait_stop();
    @(posedge ref_clk);
    eight_clock_wait <= 1'b0;
    $display("test stop_ninth done");
  endtask : t_stop_ninth
  task automatic t_stop_clear();
    pulse(1'b0);
    wr(16'hffa6, 8'h89);
    wr(16'hffa6, 8'hc8);
    #1;
    chk("leave_communication", 8'h01, {7'h00, leave_communication});
    chk("stop_trigger", 8'h00, {7'h00, stop_trigger});
    pulse(1'b0);
    wr(16'hffa6, 8'h89);
    wr(16'hffa6, 8'h00);
    #1;
    chk("stop_trigger", 8'h00, {7'h00, stop_trigger});
    wr(16'hffa6, 8'h88);
    wr(16'hffa6, 8'h89);
    pulse(1'b1);
    #1;
    chk("stop_trigger", 8'h00, {7'h00, stop_trigger});
    rd(16'hffaa);
    chk("status", 8'h40, rv);
    $display("test stop_clear done");
  endtask : t_stop_clear
  task automatic t_transmit();
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk);
    low_status <= 6'h08;
    @(posedge ref_clk);
    ninth_clock <= 1'b1;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      if (wait_release === 1'b1 && transmit_clear === 1'b1) seen = 1'b1;
    end
    chk("wait_release", 8'h01, {7'h00, seen});
    rd(16'hffaa);
    chk("status", 8'h08, rv);
    @(posedge ref_clk);
    ninth_clock <= 1'b0;
    low_status <= 6'h00;
    $display("test transmit done");
  endtask : t_transmit

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, cpu_wr, cpu_rd, start_generated, arb_lost_event} = 5'h00;
    {eight_clock_wait, ninth_clock, frame, stretch} = 4'h0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    low_status = 6'h00;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_master_arb();
    t_stop_slow();
    t_stop_ninth();
    t_stop_clear();
    t_transmit();
    wrap_up();
  end
endmodule : tb
